// file: owr_defs.svh
/*
  Offsets, field positions, reset values and counts of the write-once
  option registers. Included by every file that needs them.
*/
`ifndef OWR_DEFS_SVH
`define OWR_DEFS_SVH

`define OWR_ADDR_W 16
`define OWR_ADDR_TWO 16'h001E
`define OWR_ADDR_ONE 16'h001F

// option_latch_two fields
`define OWR_TWO_TB_SEL 2
`define OWR_TWO_OSC_STOP 1
`define OWR_TWO_BAUD_SRC 0
`define OWR_TWO_RESET 8'h01
`define OWR_TWO_MASK 8'h07

// option_latch_one fields
`define OWR_ONE_WDT_RATE 7
`define OWR_ONE_LV_STOP 6
`define OWR_ONE_LV_RSTD 5
`define OWR_ONE_LV_PWRD 4
`define OWR_ONE_LV_SUPPLY 3
`define OWR_ONE_SHORT_REC 2
`define OWR_ONE_STOP_EN 1
`define OWR_ONE_WDT_DIS 0
`define OWR_ONE_RESET 8'h00

// timing counts
`define OWR_TB_DIV 128
`define OWR_SHORT_REC_CYC 32
`define OWR_LONG_REC_CYC 4096
`define OWR_WDT_SHORT 18'h01FF0
`define OWR_WDT_LONG 18'h3FFF0

`endif

// file: owr_pkg.sv
/*
  Types shared by the option register bank and its stop recovery timer.
  Assumes owr_defs.svh is on the include path.
*/
`include "owr_defs.svh"

package owr_pkg;

  typedef logic [7:0] owr_byte_t;
  typedef logic [`OWR_ADDR_W-1:0] owr_addr_t;
  typedef enum logic {OWR_REC_IDLE, OWR_REC_COUNT} owr_rec_state_t;

endpackage : owr_pkg

// file: owr_stop_timer.sv
/*
  Stop mode recovery timer: counts crystal clock enable pulses after a
  wake request. Assumes xtal_en is a one-cycle pulse on clk.
*/
`timescale 1ns/1ps
`include "owr_defs.svh"

module owr_stop_timer #(
  parameter int SHORT_CYC = `OWR_SHORT_REC_CYC,
  parameter int LONG_CYC = `OWR_LONG_REC_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic use_short,
  input wire logic by_lvm,
  input wire logic xtal_en,
  output logic busy,
  output logic done
);
  import owr_pkg::*;

  owr_rec_state_t state_reg;
  owr_rec_state_t state_next;
  logic [12:0] count_reg;
  logic [12:0] count_next;
  logic [12:0] limit_reg;
  logic [12:0] limit_next;
  logic done_reg;
  wire short_ok = use_short & ~by_lvm;
  wire at_limit = xtal_en & (count_reg == limit_reg - 13'h0001);

  // long delay whenever the exit came from a low-voltage reset
  assign limit_next = short_ok ? 13'(SHORT_CYC) : 13'(LONG_CYC);

  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      OWR_REC_IDLE:
      begin
        count_next = 13'h0000;
        if (start)
        begin
          state_next = OWR_REC_COUNT;
        end
      end
      OWR_REC_COUNT:
      begin
        if (at_limit)
        begin
          state_next = OWR_REC_IDLE;
        end
        else if (xtal_en)
        begin
          count_next = count_reg + 13'h0001;
        end
      end
      default:
      begin
        state_next = OWR_REC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= OWR_REC_IDLE;
      count_reg <= 13'h0000;
      limit_reg <= 13'(LONG_CYC);
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      done_reg <= (state_reg == OWR_REC_COUNT) & at_limit;
      if (start && state_reg == OWR_REC_IDLE)
      begin
        limit_reg <= limit_next;
      end
    end
  end

  assign busy = (state_reg == OWR_REC_COUNT);
  assign done = done_reg;

endmodule : owr_stop_timer

// file: owr_option_regs.sv
/*
  Two write-once option registers and the option logic they steer:
  timebase prescale, oscillator in stop, baud clock source, watchdog
  rate and disable, low-voltage monitor controls, stop recovery and
  stop instruction gating.
  Assumes por_n low also pulls reset_n low; enables are clk pulses.
*/
// The register offsets and the strobed register port were decided locally.
// Functional notes
// - each register takes one write per reset
// - reset restores option defaults
// - registers at 0x1E/0x1F, freely readable
// - supply-mode bit cleared only by power-up
// - prescale select adds divide-by-128 timebase stage
// - oscillator runs in stop when set
// - baud source: bus clock 1, crystal 0
// - watchdog timeout short when set, long otherwise
// - monitor runs in stop if enabled, powered
// - reset disable blocks monitor reset requests
// - power disable turns monitor off
// - supply-mode selects 5-V or 3-V trip
// - stop recovery 32 or 4096 crystal cycles
// - monitor reset exit always uses long recovery
// - stop instruction illegal unless enabled
// - watchdog disable bit turns watchdog off
`timescale 1ns/1ps
`include "owr_defs.svh"

module owr_option_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic por_n,
  input wire owr_pkg::owr_addr_t addr,
  input wire owr_pkg::owr_byte_t wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output owr_pkg::owr_byte_t rd_data,
  input wire logic tb_src_en,
  output logic tb_tick_en,
  input wire logic stop_mode,
  output logic osc_enable,
  input wire logic bus_clk_en,
  input wire logic xtal_en,
  output logic serial_clk_en,
  output logic [17:0] watchdog_timeout,
  output logic watchdog_enable,
  input wire logic lvm_reset_req,
  output logic lvm_reset_out,
  output logic lvm_power_en,
  output logic lvm_stop_active,
  output logic lvm_5v_mode,
  input wire logic stop_instr,
  output logic stop_enter,
  output logic illegal_opcode,
  input wire logic stop_wake,
  input wire logic wake_by_lvm,
  output logic stop_recovering,
  output logic stop_recovered
);
  import owr_pkg::*;

  owr_byte_t two_reg;
  owr_byte_t one_reg;
  logic supply_reg;
  logic two_lock_reg;
  logic one_lock_reg;
  logic supply_lock_reg;
  owr_byte_t rd_data_reg;
  owr_byte_t rd_data_next;
  logic [6:0] tb_cnt_reg;
  logic lvm_meta_reg;
  logic lvm_sync_reg;
  logic stop_enter_reg;
  logic illegal_reg;

  wire hit_two = (addr == `OWR_ADDR_TWO);
  wire hit_one = (addr == `OWR_ADDR_ONE);
  wire wr_two = wr_strobe & hit_two;
  wire wr_one = wr_strobe & hit_one;
  wire take_two = wr_two & ~two_lock_reg;
  wire take_one = wr_one & ~one_lock_reg;
  wire take_supply = wr_one & ~supply_lock_reg;
  wire [7:0] one_view = {one_reg[7:4], supply_reg, one_reg[2:0]};

  wire tb_sel = two_reg[`OWR_TWO_TB_SEL];
  wire osc_stop = two_reg[`OWR_TWO_OSC_STOP];
  wire baud_src = two_reg[`OWR_TWO_BAUD_SRC];
  wire wdt_rate = one_reg[`OWR_ONE_WDT_RATE];
  wire lv_stop = one_reg[`OWR_ONE_LV_STOP];
  wire lv_rstd = one_reg[`OWR_ONE_LV_RSTD];
  wire lv_pwrd = one_reg[`OWR_ONE_LV_PWRD];
  wire short_rec = one_reg[`OWR_ONE_SHORT_REC];
  wire stop_en = one_reg[`OWR_ONE_STOP_EN];
  wire wdt_dis = one_reg[`OWR_ONE_WDT_DIS];
  wire tb_wrap = tb_src_en & (tb_cnt_reg == 7'(`OWR_TB_DIV - 1));

  // reads have no side effect; unmapped reads return zero
  assign rd_data_next = hit_two ? (two_reg & `OWR_TWO_MASK) :
                        hit_one ? one_view : 8'h00;

  // registers loaded with their defaults and locks cleared by any reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      two_reg <= `OWR_TWO_RESET;
      one_reg <= `OWR_ONE_RESET;
      two_lock_reg <= 1'b0;
      one_lock_reg <= 1'b0;
    end
    else
    begin
      if (take_two)
      begin
        two_reg <= wr_data & `OWR_TWO_MASK;
        two_lock_reg <= 1'b1;
      end
      if (take_one)
      begin
        one_reg <= wr_data;
        one_lock_reg <= 1'b1;
      end
    end
  end

  // supply-mode bit and its lock survive every reset but power-up
  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
    begin
      supply_reg <= 1'b0;
      supply_lock_reg <= 1'b0;
    end
    else if (take_supply)
    begin
      supply_reg <= wr_data[`OWR_ONE_LV_SUPPLY];
      supply_lock_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data_reg <= 8'h00;
    end
    else
    begin
      rd_data_reg <= rd_strobe ? rd_data_next : 8'h00;
    end
  end

  // extra timebase prescaler
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tb_cnt_reg <= 7'h00;
    end
    else if (tb_src_en)
    begin
      tb_cnt_reg <= tb_cnt_reg + 7'h01;
    end
  end

  // monitor reset request comes from the analog domain
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lvm_meta_reg <= 1'b0;
      lvm_sync_reg <= 1'b0;
    end
    else
    begin
      lvm_meta_reg <= lvm_reset_req;
      lvm_sync_reg <= lvm_meta_reg;
    end
  end

  // stop instruction gating
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stop_enter_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end
    else
    begin
      stop_enter_reg <= stop_instr & stop_en;
      illegal_reg <= stop_instr & ~stop_en;
    end
  end

  owr_stop_timer u_stop_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(stop_wake),
    .use_short(short_rec),
    .by_lvm(wake_by_lvm),
    .xtal_en(xtal_en),
    .busy(stop_recovering),
    .done(stop_recovered)
  );

  assign rd_data = rd_data_reg;
  assign tb_tick_en = tb_sel ? tb_wrap : tb_src_en;
  assign osc_enable = ~stop_mode | osc_stop;
  assign serial_clk_en = baud_src ? bus_clk_en : xtal_en;
  assign watchdog_timeout = wdt_rate ? `OWR_WDT_SHORT : `OWR_WDT_LONG;
  assign watchdog_enable = ~wdt_dis;
  assign lvm_reset_out = lvm_sync_reg & ~lv_rstd;
  assign lvm_power_en = ~lv_pwrd;
  assign lvm_stop_active = ~lv_pwrd & lv_stop;
  assign lvm_5v_mode = supply_reg;
  assign stop_enter = stop_enter_reg;
  assign illegal_opcode = illegal_reg;

  chk_once_locks: assert property (@(posedge clk) disable iff (!reset_n)
    wr_one && one_lock_reg |=> $stable(one_reg))
    else $error("locked option_latch_one changed");

  chk_two_once_locks: assert property (@(posedge clk) disable iff (!reset_n)
    wr_two && !two_lock_reg |=> two_lock_reg && two_reg == ($past(wr_data) & `OWR_TWO_MASK))
    else $error("first option_latch_two write lost");

  chk_reset_defaults: assert property (@(posedge clk)
    $rose(reset_n) |-> two_reg == `OWR_TWO_RESET && one_reg == `OWR_ONE_RESET)
    else $error("option defaults wrong after reset");

  chk_read_data: assert property (@(posedge clk) disable iff (!reset_n)
    rd_strobe && hit_two && !wr_strobe |=> rd_data == (two_reg & `OWR_TWO_MASK))
    else $error("option_latch_two read mismatch");

  chk_tb_divide: assert property (@(posedge clk) disable iff (!reset_n)
    tb_tick_en && tb_sel |-> tb_cnt_reg == 7'h7F && tb_src_en)
    else $error("prescaled timebase tick out of place");

  chk_osc_stop: assert property (@(posedge clk) disable iff (!reset_n)
    stop_mode && !osc_stop |-> !osc_enable)
    else $error("oscillator running in stop");

  chk_wdt_rate: assert property (@(posedge clk) disable iff (!reset_n)
    watchdog_timeout == (wdt_rate ? 18'h01FF0 : 18'h3FFF0))
    else $error("watchdog timeout wrong");

  chk_lvm_block: assert property (@(posedge clk) disable iff (!reset_n)
    $past(lvm_reset_req, 2) && $past(reset_n) && $past(reset_n, 2) && !lv_rstd |-> lvm_reset_out)
    else $error("monitor reset lost");

  chk_stop_illegal: assert property (@(posedge clk) disable iff (!reset_n)
    stop_instr |=> illegal_opcode == !$past(stop_en) && stop_enter == $past(stop_en))
    else $error("stop instruction gating wrong");

  chk_short_rec: assert property (@(posedge clk) disable iff (!reset_n)
    stop_wake && !stop_recovering && short_rec && !wake_by_lvm ##1 xtal_en [*8]
    |-> ##[1:40] stop_recovered)
    else $error("short recovery too long");

  chk_two_write_lock: assert property (@(posedge clk) disable iff (!reset_n)
    wr_two && two_lock_reg |=> $stable(two_reg) && two_lock_reg)
    else $error("locked option_latch_two changed");

  chk_one_first_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr_one && !one_lock_reg |=> one_lock_reg && one_reg == $past(wr_data))
    else $error("first option_latch_one write lost");

  chk_supply_lock: assert property (@(posedge clk) disable iff (!por_n)
    wr_one && supply_lock_reg |=> $stable(supply_reg))
    else $error("locked supply-mode bit changed");

  chk_supply_first: assert property (@(posedge clk) disable iff (!por_n)
    wr_one && !supply_lock_reg |=> supply_lock_reg && supply_reg == $past(wr_data[`OWR_ONE_LV_SUPPLY]))
    else $error("first supply-mode write lost");

  chk_read_one: assert property (@(posedge clk) disable iff (!reset_n)
    rd_strobe && hit_one && !wr_strobe |=> rd_data == one_view)
    else $error("option_latch_one read mismatch");

  chk_read_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !rd_strobe |=> rd_data == 8'h00)
    else $error("read data without a read strobe");

  chk_lvm_masked: assert property (@(posedge clk) disable iff (!reset_n)
    lv_rstd |-> !lvm_reset_out)
    else $error("blocked monitor reset passed");

  chk_lvm_power: assert property (@(posedge clk) disable iff (!reset_n)
    lv_pwrd |-> !lvm_power_en && !lvm_stop_active)
    else $error("monitor powered while disabled");

  chk_baud_src: assert property (@(posedge clk) disable iff (!reset_n)
    !baud_src |-> serial_clk_en == xtal_en)
    else $error("serial clock not from crystal");

  chk_rec_start: assert property (@(posedge clk) disable iff (!reset_n)
    stop_wake && !stop_recovering |=> stop_recovering)
    else $error("stop recovery did not start");

  chk_rec_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    stop_recovered |-> !stop_recovering ##1 !stop_recovered)
    else $error("recovery done pulse malformed");

  chk_wdt_enable: assert property (@(posedge clk) disable iff (!reset_n)
    wdt_dis |-> !watchdog_enable)
    else $error("watchdog enabled while disabled");

  chk_supply_mode: assert property (@(posedge clk) disable iff (!reset_n)
    lvm_5v_mode == supply_reg)
    else $error("monitor trip mode wrong");

endmodule : owr_option_regs

// file: test_write_once_option_registers.sv
/*
  Self-checking bench for owr_option_regs: a byte model of both option
  latches, their locks and the supply bit is compared at every result.
  Assumes owr_defs.svh on the include path and default stop timer counts.
*/
`timescale 1ns/1ps
`include "owr_defs.svh"

module test_write_once_option_registers;
  import owr_pkg::*;
  logic clk, reset_n, por_n, wr_strobe, rd_strobe, tb_src_en, tb_tick_en;
  logic stop_mode, osc_enable, bus_clk_en, xtal_en, serial_clk_en, watchdog_enable;
  logic lvm_reset_req, lvm_reset_out, lvm_power_en, lvm_stop_active, lvm_5v_mode;
  logic stop_instr, stop_enter, illegal_opcode, stop_wake, wake_by_lvm, stop_recovering, stop_recovered;
  logic [17:0] watchdog_timeout;
  owr_addr_t addr;
  owr_byte_t wr_data, rd_data, v1, v2;
  logic [7:0] m1, m2;
  logic sup, lk1, lk2, lks;
  int err_count, n_checks, seed, r;

  owr_option_regs u_dut (.clk(clk), .reset_n(reset_n), .por_n(por_n), .addr(addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .tb_src_en(tb_src_en),
    .tb_tick_en(tb_tick_en), .stop_mode(stop_mode), .osc_enable(osc_enable), .bus_clk_en(bus_clk_en),
    .xtal_en(xtal_en), .serial_clk_en(serial_clk_en), .watchdog_timeout(watchdog_timeout),
    .watchdog_enable(watchdog_enable), .lvm_reset_req(lvm_reset_req), .lvm_reset_out(lvm_reset_out),
    .lvm_power_en(lvm_power_en), .lvm_stop_active(lvm_stop_active), .lvm_5v_mode(lvm_5v_mode),
    .stop_instr(stop_instr), .stop_enter(stop_enter), .illegal_opcode(illegal_opcode),
    .stop_wake(stop_wake), .wake_by_lvm(wake_by_lvm), .stop_recovering(stop_recovering),
    .stop_recovered(stop_recovered));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic rst(input logic por);
    @(posedge clk);
    reset_n <= 1'b0;
    por_n <= !por;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    m1 = 8'h00;
    m2 = 8'h01;
    lk1 = 0;
    lk2 = 0;
    if (por)
    begin
      sup = 0;
      lks = 0;
    end
  endtask : rst

  task automatic wr(input owr_addr_t a, input owr_byte_t d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
    if (a == `OWR_ADDR_TWO && !lk2)
    begin
      m2 = d & 8'h07;
      lk2 = 1;
    end
    if (a == `OWR_ADDR_ONE && !lk1)
    begin
      m1 = d & 8'hF7;
      lk1 = 1;
      if (!lks)
      begin
        sup = d[3];
        lks = 1;
      end
    end
  endtask : wr

  task automatic rd(input owr_addr_t a, input owr_byte_t exp);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1 check(rd_data, exp);
  endtask : rd

  task automatic outs;
    @(posedge clk);
    stop_mode <= 1'b1;
    bus_clk_en <= 1'b1;
    xtal_en <= 1'b0;
    tb_src_en <= 1'b1;
    @(posedge clk);
    #1 check(watchdog_timeout, m1[7] ? 2**13 - 2**4 : 2**18 - 2**4);
    check(watchdog_enable, !m1[0]);
    check(lvm_power_en, !m1[4]);
    check(lvm_stop_active, !m1[4] && m1[6]);
    check(lvm_5v_mode, sup);
    check(osc_enable, m2[1]);
    check(serial_clk_en, m2[0]);
    repeat (255) @(posedge clk) n_checks += 0;
    stop_instr <= 1'b1;
    stop_mode <= 1'b0;
    @(posedge clk);
    stop_instr <= 1'b0;
    lvm_reset_req <= 1'b1;
    tb_src_en <= 1'b0;
    #1 check({stop_enter, illegal_opcode}, {m1[1], !m1[1]});
    check(osc_enable, 1'b1);
    repeat (3) @(posedge clk);
    #1 check(lvm_reset_out, !m1[5]);
    lvm_reset_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : outs

  task automatic ticks;
    int cnt;
    cnt = 0;
    @(posedge clk);
    tb_src_en <= 1'b1;
    repeat (256)
    begin
      @(posedge clk);
      #1 cnt += tb_tick_en;
    end
    tb_src_en <= 1'b0;
    check(cnt, m2[2] ? 2 : 256);
  endtask : ticks

  task automatic recover(input logic lvm);
    int cnt, n;
    n = (lvm || !m1[2]) ? 4096 : 32;
    cnt = 0;
    @(posedge clk);
    stop_wake <= 1'b1;
    wake_by_lvm <= lvm;
    @(posedge clk);
    stop_wake <= 1'b0;
    xtal_en <= 1'b1;
    #1 check(stop_recovering, 1'b1);
    while (cnt < 5000 && stop_recovered !== 1'b1)
    begin
      @(posedge clk);
      #1 cnt++;
    end
    check(cnt >= n && cnt <= n + 1, 1);
    check(stop_recovering, 1'b0);
    xtal_en <= 1'b0;
    wake_by_lvm <= 1'b0;
  endtask : recover

  initial
  begin
    seed = 81356;
    {reset_n, por_n, wr_strobe, rd_strobe, tb_src_en, stop_mode, bus_clk_en, xtal_en} = '0;
    {lvm_reset_req, stop_instr, stop_wake, wake_by_lvm} = '0;
    addr = '0;
    wr_data = '0;
    err_count = 0;
    n_checks = 0;
    v1 = '0;
    v2 = '0;
    sup = 0;
    lks = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    m1 = 8'h00;
    m2 = 8'h01;
    rd(`OWR_ADDR_TWO, 8'h01);
    rd(`OWR_ADDR_ONE, 8'h00);
    for (r = 0; r < 3; r++)
    begin
      rst(r != 1);
      v1 = (r == 1) ? ~v1 : (8'($random(seed)) & 8'hF3) | {4'h0, r == 2, r == 2, 2'h0};
      v2 = ((r == 1) ? ~v2 : 8'($random(seed)) & 8'hFD) | {6'h00, v1[2], 1'b0};
      wr(`OWR_ADDR_ONE, v1);
      wr(`OWR_ADDR_TWO, v2);
      wr(16'h001D, 8'($random(seed)));
      wr(`OWR_ADDR_ONE, ~v1);
      wr(`OWR_ADDR_TWO, ~v2);
      rd(`OWR_ADDR_ONE, m1 | {4'h0, sup, 3'h0});
      rd(`OWR_ADDR_TWO, m2);
      rd(16'h0020, 8'h00);
      outs;
      ticks;
      recover(r == 2);
    end
    report_and_stop;
  end

  initial
  begin
    repeat (50000) @(posedge clk);
    err_count++;
    report_and_stop;
  end
endmodule : test_write_once_option_registers
